// file: logic/assp_pkg.sv
// shared constants, types and sentence templates of the ascii sentence port
package assp_pkg;
  // device clock and bit rates
  localparam int          CLK_HZ     = 25_000_000;
  localparam int          BAUD_2400  = 2400;
  localparam int          BAUD_4800  = 4800;
  localparam int          BAUD_9600  = 9600;
  localparam int          BAUD_19200 = 19200;
  localparam int          BAUD_38400 = 38400;
  localparam int          MINUTE_S   = 60;
  localparam longint      MINUTE_CYC = longint'(MINUTE_S) * CLK_HZ;
  localparam int          CHAR_BITS  = 10;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STAT   = 8'h04;
  localparam logic [7:0]  REG_FLAG   = 8'h08;
  localparam logic [7:0]  REG_VALID  = 8'h0c;
  localparam logic [7:0]  REG_DEVST  = 8'h10;
  localparam logic [7:0]  REG_FIELD  = 8'h20;
  localparam logic [7:0]  REG_RATE   = 8'h40;
  // control field positions
  localparam int          CTRL_BAUD  = 0;
  localparam int          CTRL_CONT  = 3;
  localparam int          CTRL_UNIT  = 4;
  localparam int          CTRL_TFLT  = 6;
  localparam int          CTRL_MFLT  = 7;
  localparam int          CTRL_HALM  = 8;
  localparam int          CTRL_HABV  = 9;
  // reset values
  localparam logic [9:0]  CTRL_RST   = 10'h002;
  localparam logic [6:0]  FLAG_RST   = 7'h03;
  localparam logic [7:0]  VALID_RST  = 8'hff;
  localparam logic [11:0] RATE_RST   = 12'h000;
  localparam logic [15:0] POR_CODE   = 16'h0040;
  // framing characters
  localparam logic [7:0]  CH_DOLLAR  = 8'h24;
  localparam logic [7:0]  CH_AT      = 8'h40;
  localparam logic [7:0]  CH_STAR    = 8'h2a;
  localparam logic [7:0]  CH_COMMA   = 8'h2c;
  localparam logic [7:0]  CH_CR      = 8'h0d;
  localparam logic [7:0]  CH_LF      = 8'h0a;
  localparam int          SENT_N     = 7;
  localparam int          TMPL_LEN   = 64;
  // '#n' numeric field n, '%m/%p/%r' status char, '&' maker prefix char
  localparam bit [511:0]  TMPL_HDT = "HCHDT,#0,T";
  localparam bit [511:0]  TMPL_HDG = "HCHDG,#0,0.0,E,0.0,E";
  localparam bit [511:0]  TMPL_XDR =
    "HCXDR,A,#1,D,PITCH,A,#2,D,ROLL,G,#5,MAGX,G,#6,MAGY,G,#7,MAGZ";
  // proprietary names are spelled as ascii bytes
  localparam bit [511:0]  TMPL_HTF =
    {"&&&&", 24'h48544d, ",#0,%m,#1,%p,#2,%r,#3,#4"};
  localparam bit [511:0]  TMPL_NRM =
    {"&&&&", 24'h4e4344, ",#1,#2,#5,#6,#4,#3,#0"};
  localparam bit [511:0]  TMPL_CND =
    {"&&&&", 24'h434344, ",#1,#2,#5,#6,#7,#4,#0"};
  localparam bit [511:0]  TMPL_RAW =
    {"&&&&", 24'h524344, ",#1,#2,#5,#6,#7"};

  typedef enum logic [1:0] {UNIT_DEG, UNIT_MIL, UNIT_MRAD, UNIT_INT}
    assp_unit_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } assp_wb_req_t;
endpackage

// file: logic/assp_top.sv
// ascii sentence serial port: wishbone registers, uart, query parser, framer
`timescale 1ns/1ns
//
// Contract
// - characters are start, eight data bits lsb first, stop; top bit zero.
// - bit rate 2400, 4800, 9600 or 19200; 38400 on the fast variant.
// - receiver runs independently, accepting input even while sending.
// - a sentence in progress always completes before a reply starts.
// - dollar starts a data request, at sign a setup command; routed apart.
// - sentence is dollar, identifier, comma fields, star, checksum, cr lf.
// - undeterminable field is sent empty, giving two adjacent commas.
// - heading is empty when tilt or magnetic sensor is faulty.
// - fields are decimal; angles carry a point when unit is degrees.
// - other angle units are plain integers: mils, milliradians, 16 bit.
// - standard true heading, heading/deviation and transducer sentences.
// - four maker-prefixed sentences: field, normalized, conditioned, raw.
// - field sentence has heading, pitch, roll, dip, field, status chars.
// - continuous mode sends each sentence at its own per-minute rate.
// - a valid query is answered with the one sentence it names.
// - standard queries accept any two-character talker if checksum good.
// - checksum is xor of chars between start and star, two hex chars.
// - horizontal field alarm shows M below or O above, no blanking.
// - identification status code 0040 marks a power-on reset.
// - setup commands carry the same xor checksum after the at sign.
// - magnetometer status is one of C, L, M, N, O, P, V.
module assp_top #(
  parameter longint      MINUTE_CYC = assp_pkg::MINUTE_CYC,
  parameter bit          FAST       = 1'b1,
  parameter logic [31:0] MAKER      = "PXXX"  // arbitrary maker prefix
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // wishbone slave
  input  wire assp_pkg::assp_wb_req_t wb_i,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  // serial pins
  input  wire logic                   rxd,
  output logic                        txd
);
  localparam int N = assp_pkg::SENT_N;

  logic [9:0]  ctrl_q;
  logic [6:0]  flag_q;
  logic [7:0]  valid_q;
  logic        por_q;
  logic [15:0] fld_q [8];
  logic [11:0] rate_q [N];
  logic [N-1:0] pend_q, fire, qset, take;
  logic [7:0]  bad_q, setup_q;
  logic        tx_busy_q, tx_go;
  logic [7:0]  ch;
  logic        emit;
  logic [15:0] div;
  logic        wr;

  // bit period in clocks for the selected rate
  always_comb begin
    unique case (ctrl_q[assp_pkg::CTRL_BAUD +: 3])
      3'h0:    div = 16'(assp_pkg::CLK_HZ / assp_pkg::BAUD_2400);
      3'h1:    div = 16'(assp_pkg::CLK_HZ / assp_pkg::BAUD_4800);
      3'h2:    div = 16'(assp_pkg::CLK_HZ / assp_pkg::BAUD_9600);
      3'h4:    div = FAST ? 16'(assp_pkg::CLK_HZ / assp_pkg::BAUD_38400)
                          : 16'(assp_pkg::CLK_HZ / assp_pkg::BAUD_19200);
      default: div = 16'(assp_pkg::CLK_HZ / assp_pkg::BAUD_19200);
    endcase
  end

  // wishbone: one wait state, ack drops the cycle after it rises
  assign wr = wb_i.cyc & wb_i.stb & wb_i.we & ~wb_ack_o;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_i.cyc & wb_i.stb & ~wb_ack_o;
    end
  end

  // read mux; unmapped words read zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= 32'h0;
      if (wb_i.adr >= assp_pkg::REG_RATE
          && wb_i.adr < assp_pkg::REG_RATE + 8'(4 * N)) begin
        wb_dat_o <= {20'h0, rate_q[3'(wb_i.adr[4:2])]};
      end else if (wb_i.adr >= assp_pkg::REG_FIELD
                   && wb_i.adr < assp_pkg::REG_RATE) begin
        wb_dat_o <= {16'h0, fld_q[wb_i.adr[4:2]]};
      end else begin
        unique case (wb_i.adr)
          assp_pkg::REG_CTRL:  wb_dat_o <= {22'h0, ctrl_q};
          assp_pkg::REG_STAT:
            wb_dat_o <= {8'h0, setup_q, bad_q, tx_busy_q, pend_q};
          assp_pkg::REG_FLAG:  wb_dat_o <= {25'h0, flag_q};
          assp_pkg::REG_VALID: wb_dat_o <= {24'h0, valid_q};
          assp_pkg::REG_DEVST:
            wb_dat_o <= {16'h0, por_q ? assp_pkg::POR_CODE : 16'h0};
          default:             wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // control, flag and validity registers; control takes byte lanes 0 and 1, the others lane 0 only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q  <= assp_pkg::CTRL_RST;
      flag_q  <= assp_pkg::FLAG_RST;
      valid_q <= assp_pkg::VALID_RST;
      por_q   <= 1'b1;
    end else if (wr) begin
      if (wb_i.adr == assp_pkg::REG_CTRL) begin
        if (wb_i.sel[0]) ctrl_q[7:0] <= wb_i.dat[7:0];
        if (wb_i.sel[1]) ctrl_q[9:8] <= wb_i.dat[9:8];
      end
      if (wb_i.adr == assp_pkg::REG_FLAG && wb_i.sel[0])
        flag_q <= wb_i.dat[6:0];
      if (wb_i.adr == assp_pkg::REG_VALID && wb_i.sel[0])
        valid_q <= wb_i.dat[7:0];
      // writing bit 6 clears the power-on mark
      if (wb_i.adr == assp_pkg::REG_DEVST && wb_i.sel[0] && wb_i.dat[6])
        por_q <= 1'b0;
    end
  end

  // measurement fields and per-sentence rates
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_fld
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          fld_q[gi] <= 16'h0;
        end else if (wr && wb_i.adr == assp_pkg::REG_FIELD + 8'(4 * gi)) begin
          if (wb_i.sel[0]) fld_q[gi][7:0]  <= wb_i.dat[7:0];
          if (wb_i.sel[1]) fld_q[gi][15:8] <= wb_i.dat[15:8];
        end
      end
    end
    for (gi = 0; gi < N; gi++) begin : g_rate
      logic [31:0] acc_q;
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          rate_q[gi] <= assp_pkg::RATE_RST;
        end else if (wr && wb_i.adr == assp_pkg::REG_RATE + 8'(4 * gi)) begin
          if (wb_i.sel[0]) rate_q[gi][7:0]  <= wb_i.dat[7:0];
          if (wb_i.sel[1]) rate_q[gi][11:8] <= wb_i.dat[11:8];
        end
      end
      // rate accumulator avoids a divider: fires rate times per minute
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          acc_q <= 32'h0;
        end else if (!ctrl_q[assp_pkg::CTRL_CONT]) begin
          acc_q <= 32'h0;
        end else if (acc_q + 32'(rate_q[gi]) >= 32'(MINUTE_CYC)) begin
          acc_q <= acc_q + 32'(rate_q[gi]) - 32'(MINUTE_CYC);
        end else begin
          acc_q <= acc_q + 32'(rate_q[gi]);
        end
      end
      assign fire[gi] = ctrl_q[assp_pkg::CTRL_CONT] && rate_q[gi] != 12'h0
                        && acc_q + 32'(rate_q[gi]) >= 32'(MINUTE_CYC);
    end
  endgenerate

  // pending sentences; a new request wins over the clear of the same bit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) pend_q <= '0;
    else pend_q <= (pend_q & ~take) | fire | qset;
  end

  // ---------------- receiver ----------------
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic        rx_act_q, rx_vld_q;
  logic [7:0]  rx_sh_q, rx_byte_q;
  // runs on its own regardless of the transmitter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_act_q <= 1'b0;
      rx_vld_q <= 1'b0;
      rx_cnt_q <= 16'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 8'h0;
      rx_byte_q <= 8'h0;
    end else begin
      rx_vld_q <= 1'b0;
      if (!rx_act_q) begin
        if (!rxd) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= div >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0) begin
        rx_cnt_q <= rx_cnt_q - 16'h1;
      end else begin
        rx_cnt_q <= div - 16'h1;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rxd) rx_act_q <= 1'b0;  // glitch, no start
        if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8)
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        if (rx_bit_q == 4'h9) begin
          rx_act_q  <= 1'b0;
          rx_vld_q  <= rxd;           // framing error drops the char
          rx_byte_q <= rx_sh_q;
        end
      end
    end
  end

  // ---------------- query parser ----------------
  typedef enum {P_IDLE, P_BODY, P_H1, P_H2, P_CR, P_LF} assp_pst_t;
  assp_pst_t   ps_q;
  logic        at_q;
  logic [7:0]  rbuf_q [9];
  logic [3:0]  rlen_q;
  logic [7:0]  rsum_q;
  logic [3:0]  rhi_q;
  logic [4:0]  nib;
  logic [2:0]  qidx;

  // hex digit of either case; bit 4 flags a non-hex char
  always_comb begin
    if (rx_byte_q >= "0" && rx_byte_q <= "9")
      nib = {1'b0, 4'(rx_byte_q - "0")};
    else if (rx_byte_q >= "A" && rx_byte_q <= "F")
      nib = {1'b0, 4'(rx_byte_q - "A" + 8'h0a)};
    else if (rx_byte_q >= "a" && rx_byte_q <= "f")
      nib = {1'b0, 4'(rx_byte_q - "a" + 8'h0a)};
    else nib = 5'h10;
  end

  // which sentence the buffered query names; 7 means none
  always_comb begin
    qidx = 3'h7;
    if (rlen_q == 4'h9 && {rbuf_q[2], rbuf_q[3], rbuf_q[4]} == "HCQ"
        && rbuf_q[5] == assp_pkg::CH_COMMA) begin
      unique case ({rbuf_q[6], rbuf_q[7], rbuf_q[8]})
        "HDT":   qidx = 3'h0;
        "HDG":   qidx = 3'h1;
        "XDR":   qidx = 3'h2;
        default: qidx = 3'h7;
      endcase
    end else if (rlen_q == 4'h8 && rbuf_q[4] == assp_pkg::CH_COMMA
        && {rbuf_q[0], rbuf_q[1], rbuf_q[2], rbuf_q[3]} == MAKER) begin
      unique case ({rbuf_q[5], rbuf_q[6], rbuf_q[7]})
        24'h48544d: qidx = 3'h3;
        24'h4e4344: qidx = 3'h4;
        24'h434344: qidx = 3'h5;
        24'h524344: qidx = 3'h6;
        default: qidx = 3'h7;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ps_q    <= P_IDLE;
      at_q    <= 1'b0;
      rlen_q  <= 4'h0;
      rsum_q  <= 8'h0;
      rhi_q   <= 4'h0;
      bad_q   <= 8'h0;
      setup_q <= 8'h0;
      qset    <= '0;
      for (int i = 0; i < 9; i++) rbuf_q[i] <= 8'h0;
    end else begin
      qset <= '0;
      if (rx_vld_q) begin
        if (rx_byte_q == assp_pkg::CH_DOLLAR
            || rx_byte_q == assp_pkg::CH_AT) begin
          ps_q   <= P_BODY;
          at_q   <= rx_byte_q == assp_pkg::CH_AT;
          rlen_q <= 4'h0;
          rsum_q <= 8'h0;
        end else begin
          unique case (ps_q)
            P_IDLE: ps_q <= P_IDLE;
            P_BODY: begin
              if (rx_byte_q == assp_pkg::CH_STAR) begin
                ps_q <= P_H1;
              end else begin
                rsum_q <= rsum_q ^ rx_byte_q;
                if (!at_q && rlen_q < 4'h9) rbuf_q[rlen_q] <= rx_byte_q;
                if (rlen_q != 4'hf) rlen_q <= rlen_q + 4'h1;
              end
            end
            P_H1: begin
              rhi_q <= nib[3:0];
              ps_q  <= nib[4] ? P_IDLE : P_H2;
              if (nib[4]) bad_q <= bad_q + 8'h1;
            end
            P_H2: begin
              ps_q <= (nib[4] || {rhi_q, nib[3:0]} != rsum_q) ? P_IDLE : P_CR;
              if (nib[4] || {rhi_q, nib[3:0]} != rsum_q)
                bad_q <= bad_q + 8'h1;
            end
            P_CR: ps_q <= rx_byte_q == assp_pkg::CH_CR ? P_LF : P_IDLE;
            P_LF: begin
              ps_q <= P_IDLE;
              if (rx_byte_q == assp_pkg::CH_LF) begin
                // setup commands are not decoded, only counted here
                if (at_q) setup_q <= setup_q + 8'h1;
                else if (qidx != 3'h7) qset[qidx] <= 1'b1;
                else bad_q <= bad_q + 8'h1;
              end
            end
          endcase
        end
      end
    end
  end

  // ---------------- sentence framer ----------------
  typedef enum {F_IDLE, F_DOLLAR, F_TMPL, F_NUM, F_STAR, F_HI, F_LO,
                F_CR, F_LF} assp_fst_t;
  assp_fst_t   fs_q;
  logic [2:0]  sent_q;
  logic [6:0]  idx_q;
  logic [1:0]  pc_q;
  logic [7:0]  csum_q;
  logic [19:0] dig_q;
  logic [2:0]  rem_q;
  logic        pt_q;
  logic [511:0] tmpl;
  logic [7:0]  tc, tn;
  logic [2:0]  fsel;
  logic        hd_blank, fnull;
  logic [19:0] bcd;
  logic [2:0]  nd;

  always_comb begin
    unique case (sent_q)
      3'h0:    tmpl = assp_pkg::TMPL_HDT;
      3'h1:    tmpl = assp_pkg::TMPL_HDG;
      3'h2:    tmpl = assp_pkg::TMPL_XDR;
      3'h3:    tmpl = assp_pkg::TMPL_HTF;
      3'h4:    tmpl = assp_pkg::TMPL_NRM;
      3'h5:    tmpl = assp_pkg::TMPL_CND;
      default: tmpl = assp_pkg::TMPL_RAW;
    endcase
    tc   = tmpl[511 - 8 * int'(idx_q[5:0]) -: 8];
    tn   = tmpl[511 - 8 * int'(6'(idx_q[5:0] + 6'h1)) -: 8];
    fsel = 3'(tn - "0");
  end

  // heading blanks on sensor faults or any alarm status; not on field alarm
  assign hd_blank = ctrl_q[assp_pkg::CTRL_TFLT] || ctrl_q[assp_pkg::CTRL_MFLT]
                    || flag_q[2:0] == 3'h0 || flag_q[2:0] == 3'h1
                    || flag_q[2:0] >= 3'h5 || flag_q[4:3] == 2'h2
                    || flag_q[6:5] == 2'h2;
  assign fnull = !valid_q[fsel] || (fsel == 3'h0 && hd_blank);

  // binary to five decimal digits, and count of digits to send
  always_comb begin
    bcd = 20'h0;
    for (int i = 15; i >= 0; i--) begin
      for (int d = 0; d < 5; d++)
        if (bcd[4*d +: 4] > 4'h4) bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
      bcd = {bcd[18:0], fld_q[fsel][i]};
    end
    nd = 3'h1;
    for (int d = 1; d < 5; d++)
      if (bcd[4*d +: 4] != 4'h0) nd = 3'(d + 1);
    if (fsel <= 3'h3 && ctrl_q[assp_pkg::CTRL_UNIT +: 2] == assp_pkg::UNIT_DEG
        && nd == 3'h1) nd = 3'h2;     // keep a leading zero before the point
  end

  // character offered by the framer in each state
  always_comb begin
    emit = 1'b1;
    ch   = 8'h0;
    unique case (fs_q)
      F_IDLE:   emit = 1'b0;
      F_DOLLAR: ch = assp_pkg::CH_DOLLAR;
      F_TMPL: begin
        if (tc == 8'h0 || tc == "#") emit = 1'b0;
        else if (tc == "&") ch = MAKER[8 * (3 - int'(pc_q)) +: 8];
        else if (tc == "%" && tn == "m") begin
          if (ctrl_q[assp_pkg::CTRL_HALM])
            ch = ctrl_q[assp_pkg::CTRL_HABV] ? "O" : "M";
          else
            unique case (flag_q[2:0])
              3'h0:    ch = "C";
              3'h1:    ch = "L";
              3'h2:    ch = "M";
              3'h3:    ch = "N";
              3'h4:    ch = "O";
              3'h5:    ch = "P";
              default: ch = "V";
            endcase
        end else if (tc == "%") begin
          unique case (tn == "p" ? flag_q[4:3] : flag_q[6:5])
            2'h1:    ch = "O";
            2'h2:    ch = "P";
            default: ch = "N";
          endcase
        end else ch = tc;
      end
      // point sits before the last digit in degrees
      F_NUM: ch = (pt_q && rem_q == 3'h2) ? "." : {4'h3, dig_q[19:16]};
      F_STAR: ch = assp_pkg::CH_STAR;
      F_HI: ch = csum_q[7:4] > 4'h9 ? 8'h37 + csum_q[7:4]
                                    : 8'h30 + csum_q[7:4];
      F_LO: ch = csum_q[3:0] > 4'h9 ? 8'h37 + csum_q[3:0]
                                    : 8'h30 + csum_q[3:0];
      F_CR: ch = assp_pkg::CH_CR;
      F_LF: ch = assp_pkg::CH_LF;
    endcase
  end
  assign tx_go = emit && !tx_busy_q;

  // picks the lowest pending sentence only when idle
  always_comb begin
    take = '0;
    if (fs_q == F_IDLE)
      for (int i = N - 1; i >= 0; i--)
        if (pend_q[i]) take = N'(1) << i;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fs_q <= F_IDLE;
      sent_q <= 3'h0;
      idx_q <= 7'h0;
      pc_q <= 2'h0;
      csum_q <= 8'h0;
      dig_q <= 20'h0;
      rem_q <= 3'h0;
      pt_q <= 1'b0;
    end else begin
      unique case (fs_q)
        F_IDLE: if (pend_q != '0) begin
          fs_q <= F_DOLLAR;
          for (int i = N - 1; i >= 0; i--) if (pend_q[i]) sent_q <= 3'(i);
        end
        F_DOLLAR: if (tx_go) begin
          fs_q <= F_TMPL;
          idx_q <= 7'h0;
          pc_q <= 2'h0;
          csum_q <= 8'h0;
        end
        F_TMPL: if (!emit || tx_go) begin
          if (emit) csum_q <= csum_q ^ ch;
          if (tc == "&") pc_q <= pc_q + 2'h1;
          if (tc == "#" && !fnull) begin
            fs_q  <= F_NUM;
            pt_q  <= fsel <= 3'h3 && ctrl_q[assp_pkg::CTRL_UNIT +: 2]
                     == assp_pkg::UNIT_DEG;
            rem_q <= (fsel <= 3'h3 && ctrl_q[assp_pkg::CTRL_UNIT +: 2]
                      == assp_pkg::UNIT_DEG) ? nd + 3'h1 : nd;
            dig_q <= bcd << (4 * (5 - int'(nd)));
          end
          if (tc == "#" || tc == "%") idx_q <= idx_q + 7'h2;
          else idx_q <= idx_q + 7'h1;
          if (idx_q >= 7'(assp_pkg::TMPL_LEN - 1) && tc != "#")
            fs_q <= F_STAR;
        end
        F_NUM: if (tx_go) begin
          csum_q <= csum_q ^ ch;
          rem_q  <= rem_q - 3'h1;
          if (!(pt_q && rem_q == 3'h2)) dig_q <= dig_q << 4;
          if (rem_q == 3'h1) fs_q <= F_TMPL;
        end
        F_STAR: if (tx_go) fs_q <= F_HI;
        F_HI:   if (tx_go) fs_q <= F_LO;
        F_LO:   if (tx_go) fs_q <= F_CR;
        F_CR:   if (tx_go) fs_q <= F_LF;
        F_LF:   if (tx_go) fs_q <= F_IDLE;
      endcase
    end
  end

  // ---------------- transmitter ----------------
  logic [8:0]  tx_sh_q;
  logic [3:0]  tx_bits_q;
  logic [15:0] tx_cnt_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txd       <= 1'b1;
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 9'h1ff;
      tx_bits_q <= 4'h0;
      tx_cnt_q  <= 16'h0;
    end else if (tx_go) begin
      txd       <= 1'b0;
      tx_sh_q   <= {1'b1, 1'b0, ch[6:0]};
      tx_bits_q <= 4'(assp_pkg::CHAR_BITS - 1);
      tx_cnt_q  <= div - 16'h1;
      tx_busy_q <= 1'b1;
    end else if (tx_busy_q) begin
      if (tx_cnt_q != 16'h0) begin
        tx_cnt_q <= tx_cnt_q - 16'h1;
      end else begin
        tx_cnt_q <= div - 16'h1;
        if (tx_bits_q == 4'h0) begin
          tx_busy_q <= 1'b0;
        end else begin
          txd       <= tx_sh_q[0];
          tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
        end
      end
    end
  end
endmodule

// file: test/assp_assertions.sv
// pin checker of the sentence port, bound to the top
`timescale 1ns/1ns
module assp_chk (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   nrst,
  // bus and serial pins
  input wire assp_pkg::assp_wb_req_t wb_i,
  input wire logic                   wb_ack_o,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   rxd,
  input wire logic                   txd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic        rd;
  logic        tx_q;
  logic [11:0] run_q;
  assign rd = wb_i.cyc & wb_i.stb & ~wb_i.we & ~wb_ack_o;
  // cycles since txd moved; saturates so long idle never wraps
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_q  <= 1'b1;
      run_q <= '1;
    end else begin
      tx_q  <= txd;
      run_q <= (txd != tx_q) ? '0 : run_q + {11'h0, ~&run_q};
    end
  end
  AST_ACK_LAT: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o
    |=> wb_ack_o) else $error("ack not one cycle after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  AST_UNMAP: assert property (rd && wb_i.adr == 8'hfc |=> wb_dat_o == '0)
    else $error("unmapped read not zero");
  AST_CTRL_W: assert property (rd && wb_i.adr == assp_pkg::REG_CTRL
    |=> wb_dat_o[31:10] == '0) else $error("ctrl upper bits set");
  AST_STAT_W: assert property (rd && wb_i.adr == assp_pkg::REG_STAT
    |=> wb_dat_o[31:24] == '0) else $error("status upper bits set");
  AST_TXD_RST: assert property ($rose(nrst) |-> (txd && !wb_ack_o) [*2])
    else $error("txd or ack active after reset");
  AST_TXD_BIT: assert property (txd != tx_q |-> run_q >= 12'd640)
    else $error("serial bit too short");
  CVR_TX: cover property (txd != tx_q && !txd);
  CVR_STAT: cover property (rd && wb_i.adr == assp_pkg::REG_STAT);
  CVR_RX: cover property ($fell(rxd));
endmodule
bind assp_top assp_chk chk (.mclk(mclk), .nrst(nrst), .wb_i(wb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rxd(rxd), .txd(txd));

// file: test/assp_host.sv
// host computer model: character sender and collector
`timescale 1ns/1ns
module assp_host #(
  parameter int DIV = 651
) (
  // clock
  input wire logic mclk,
  // serial pins of the device
  input wire logic txd,
  output logic     rxd
);
  logic [7:0] got [$];
  int         ferr = 0;
  initial rxd = 1'b1;
  // start, eight bits lsb first, stop; idle high
  task automatic send(input string s);
    logic [9:0] f;
    for (int c = 0; c < s.len(); c++) begin
      f = {1'b1, s[c], 1'b0};
      for (int b = 0; b < 10; b++) begin
        rxd <= f[b];
        repeat (DIV) @(posedge mclk);
      end
    end
  endtask
  // mid-bit sampling; bad start, stop or top bit is a framing fault
  always begin
    logic [9:0] r;
    @(negedge txd);
    repeat (DIV / 2) @(posedge mclk);
    for (int b = 0; b < 10; b++) begin
      r[b] = txd;
      if (b < 9) repeat (DIV) @(posedge mclk);
    end
    if (r[0] || r[8] || !r[9]) ferr++;
    got.push_back(r[8:1]);
  end
endmodule

// file: test/tb_assp_top.sv
// bench: register checks and one framed sentence during a query
`timescale 1ns/1ns
module tb_assp_top;
  logic                   mclk = 1'b0;
  logic                   nrst = 1'b0;
  assp_pkg::assp_wb_req_t wb_i = '0;
  logic                   wb_ack_o;
  logic [31:0]            wb_dat_o;
  logic                   rxd;
  logic                   txd;
  logic [31:0]            q;
  int                     n_mismatch = 0;
  int                     n_checks = 0;
  string                  s;
  always #20 mclk = ~mclk;
  assp_top #(.MINUTE_CYC(6000)) dut (.mclk(mclk), .nrst(nrst), .wb_i(wb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rxd(rxd), .txd(txd));
  assp_host #(.DIV(651)) host (.mclk(mclk), .txd(txd), .rxd(rxd));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // single cycle; held until ack, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    wb_i <= '{1'b1, 1'b1, w, a, 4'h3, d};
    do begin @(posedge mclk); i++; end while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    wb_i <= '0;
    @(posedge mclk);
    if (i >= 20) begin n_mismatch++; end_sim(); end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 10) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // full sentence around a body, upper-case xor sum
  function automatic string snt(input string b);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < b.len(); i++) x ^= b[i];
    return $sformatf("$%s*%c%c\015\012", b, hx(x[7:4]), hx(x[3:0]));
  endfunction
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    wb(1'b0, assp_pkg::REG_CTRL, 32'h0);
    chk(q, 32'h002);
    wb(1'b0, assp_pkg::REG_FLAG, 32'h0);
    chk(q, 32'h003);
    wb(1'b0, assp_pkg::REG_DEVST, 32'h0);
    chk(q, 32'h040);
    wb(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h000);
    // rate timer sends; magnetic fault blanks heading
    wb(1'b1, assp_pkg::REG_RATE, 32'h1);
    wb(1'b1, assp_pkg::REG_CTRL, 32'h08c);
    // query with wrong sum arrives while the sentence goes out
    fork host.send("$PXXX,HDT*00\015\012"); join_none
    s = snt("HCHDT,,T");
    for (int i = 0; i < 99000 && host.got.size() < s.len(); i++)
      @(posedge mclk);
    chk(32'(host.got.size()), 32'(s.len()));
    for (int i = 0; i < host.got.size() && i < s.len(); i++)
      chk(32'(host.got[i]), 32'(s[i]));
    repeat (700) @(posedge mclk);
    wb(1'b0, assp_pkg::REG_STAT, 32'h0);
    chk(32'(q[15:8]), 32'h001);
    chk(32'(host.ferr), 32'h000);
    end_sim();
  end
endmodule
